/* blps_pkg.sv */
// Constants, register map and state encoding of the burner, limit and pump sequencer.
// Assumes a single 125 MHz pclk and a 32-bit APB register bus.
package blps_pkg;

    // Clock rate and the time units built on it.
    localparam int CLK_PERIOD_NS = 8;
    localparam int SEC_NS = 1_000_000_000;
    localparam int TICKS_PER_SEC = SEC_NS / CLK_PERIOD_NS;
    localparam int SEC_PER_MIN = 60;
    localparam int TICK_W = 27;

    // Fixed sequence times in seconds.
    localparam logic [15:0] PURGE_TIME_S = 16'h000a;
    localparam logic [15:0] IGN_TIME_S = 16'h0004;

    // Register byte offsets.
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_LIGHTOFF = 12'h004;
    localparam logic [11:0] OFS_STAB = 12'h008;
    localparam logic [11:0] OFS_RAMP = 12'h00c;
    localparam logic [11:0] OFS_SLOW_SP = 12'h010;
    localparam logic [11:0] OFS_STACK_SP = 12'h014;
    localparam logic [11:0] OFS_STACK_DLY = 12'h018;
    localparam logic [11:0] OFS_STACK_BAND = 12'h01c;
    localparam logic [11:0] OFS_OVERRUN = 12'h020;
    localparam logic [11:0] OFS_PWM_DIV = 12'h024;
    localparam logic [11:0] OFS_CYCLES = 12'h028;
    localparam logic [11:0] OFS_STATUS = 12'h02c;
    localparam logic [11:0] OFS_IRQ_STS = 12'h030;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h034;
    localparam logic [11:0] OFS_TEMP_DISP = 12'h038;

    // Control register fields.
    localparam int CB_RUN_RECYCLE = 0;
    localparam int CB_SLOW_EN = 1;
    localparam int CB_STACK_EN = 2;
    localparam int CB_STACK_RECYCLE = 3;
    localparam int CB_PUMP_MANUAL = 4;
    localparam int CB_CELSIUS = 5;
    localparam int CB_PUMP_SEL_LO = 8;
    localparam int CB_PUMP_SEL_HI = 9;
    localparam int CTRL_W = 10;

    // Interrupt status bits.
    localparam int IB_FLAME = 0;
    localparam int IB_STACK = 1;
    localparam int IB_LOCK = 2;
    localparam int IB_PUMP = 3;
    localparam int IRQ_W = 4;

    // Reset values and rate figures in percent.
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h101;
    localparam logic [7:0] LIGHTOFF_RST = 8'h19;
    localparam logic [7:0] PREPURGE_RATE = 8'h64;
    localparam logic [7:0] RATE_MAX = 8'h64;
    localparam logic [7:0] STEP_CAP1 = 8'h4b;
    localparam logic [7:0] STEP_CAP2 = 8'h32;
    localparam logic [7:0] STEP_CAP3 = 8'h19;
    localparam logic [15:0] PWM_DIV_RST = 16'h0032;

    // Fahrenheit to Celsius: subtract 32, scale by 5/9 as 2276/4096.
    localparam logic [15:0] F_OFFSET = 16'h0020;
    localparam logic [11:0] C_SCALE = 12'h8e4;
    localparam int C_SHIFT = 12;

    // Burner states, Gray coded along idle, purge, ignite, stabilise, run.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PURGE = 3'b001,
        ST_IGNITE = 3'b011,
        ST_STAB = 3'b010,
        ST_RUN = 3'b110,
        ST_HOLD = 3'b111,
        ST_LOCK = 3'b101
    } blps_state_t;

endpackage

/* blps_pwm.sv */
// Fan drive pulse-width modulator with a programmable step length.
// Assumes duty in percent and a step divider from the register file.
module blps_pwm
    import blps_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Settings.
    input wire logic [15:0] div,
    input wire logic [7:0] duty,
    // Drive output.
    output logic pwm_out
);

    logic [15:0] pre_q;
    logic [7:0] step_q;
    logic pwm_q;
    wire step_end = (pre_q >= div - 16'h0001) || (div == 16'h0000);
    wire [7:0] step_nx = (step_q >= RATE_MAX - 8'h01) ? 8'h00 : step_q + 8'h01;

    // One period is a hundred steps of div clocks each.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 16'h0000;
            step_q <= 8'h00;
            pwm_q <= 1'b0;
        end else begin
            pre_q <= step_end ? 16'h0000 : pre_q + 16'h0001;
            if (step_end) begin
                step_q <= step_nx;
            end
            pwm_q <= step_q < duty;
        end
    end

    assign pwm_out = pwm_q;

endmodule

/* blps_top.sv */
// Burner recycle, run stabilisation, slow start, stack limit and system pump sequencer.
// Assumes sensor temperatures arrive from logic on pclk, flame and demand from pins.
module blps_top
    import blps_pkg::*;
#(
    parameter int TICKS_PER_SEC_P = TICKS_PER_SEC,
    parameter int PUMP_OUTS = 3
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and sensor values.
    input wire logic flame_in,
    input wire logic demand_in,
    input wire logic [15:0] outlet_temp,
    input wire logic [15:0] stack_temp,
    input wire logic [7:0] rate_req,
    // Burner drive.
    output logic fan_on,
    output logic fan_pwm,
    output logic igniter_on,
    output logic valve_on,
    output logic lockout,
    output logic [7:0] mod_rate,
    // Pumps, units and interrupt.
    output logic [PUMP_OUTS-1:0] pump_out,
    output logic units_celsius,
    output logic irq
);

    // Pin synchronisers.
    logic flame_m_q, flame_s_q, dem_m_q, dem_s_q;
    // Register file.
    logic [CTRL_W-1:0] ctrl_q;
    logic [7:0] lightoff_q, ramp_q;
    logic [15:0] stab_q, slow_sp_q, stack_sp_q, stack_dly_q, band_q, overrun_q, pwm_div_q;
    logic [31:0] cycles_q, prdata_q;
    logic [IRQ_W-1:0] irq_sts_q, irq_mask_q, irq_ev;
    // Sequencer and timers.
    blps_state_t state_q, state_d;
    logic [TICK_W-1:0] tick_q;
    logic [5:0] min_q;
    logic [15:0] seq_sec_q, ovr_sec_q;
    logic ovr_run_q, pump_q, routed_prev_q;
    logic [7:0] rate_q, rate_d, ceil_q;
    logic ign_q, valve_q, fan_q, lock_q;
    logic ev_flame, ev_stack, ev_lock;

    // Two flip-flops on each pin before any logic reads it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flame_m_q <= 1'b0;
            flame_s_q <= 1'b0;
            dem_m_q <= 1'b0;
            dem_s_q <= 1'b0;
        end else begin
            flame_m_q <= flame_in;
            flame_s_q <= flame_m_q;
            dem_m_q <= demand_in;
            dem_s_q <= dem_m_q;
        end
    end

    // Control fields.
    wire run_recycle = ctrl_q[CB_RUN_RECYCLE];
    wire slow_en = ctrl_q[CB_SLOW_EN];
    wire stack_en = ctrl_q[CB_STACK_EN];
    wire stack_recycle = ctrl_q[CB_STACK_RECYCLE];
    wire pump_manual = ctrl_q[CB_PUMP_MANUAL];
    wire celsius = ctrl_q[CB_CELSIUS];
    wire [1:0] pump_sel = ctrl_q[CB_PUMP_SEL_HI:CB_PUMP_SEL_LO];

    // Second and minute ticks.
    wire sec_tick = tick_q == TICK_W'(TICKS_PER_SEC_P - 1);
    wire min_tick = sec_tick && (min_q == 6'(SEC_PER_MIN - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= '0;
            min_q <= 6'h00;
        end else begin
            tick_q <= sec_tick ? '0 : tick_q + TICK_W'(1);
            if (sec_tick) begin
                min_q <= min_tick ? 6'h00 : min_q + 6'h01;
            end
        end
    end

    // Elapsed whole seconds in the current state reach a set time.
    wire [15:0] seq_nx = seq_sec_q + 16'h0001;
    wire purge_done = sec_tick && (seq_nx >= PURGE_TIME_S);
    wire ign_done = sec_tick && (seq_nx >= IGN_TIME_S);
    wire stab_done = sec_tick && (seq_nx >= stab_q);
    wire dly_done = sec_tick && (seq_nx >= stack_dly_q);
    wire stab_zero = stab_q == 16'h0000;
    wire stack_trip = stack_en && (stack_temp > stack_sp_q);

    // Burner sequence.
    always_comb begin
        state_d = state_q;
        ev_flame = 1'b0;
        ev_stack = 1'b0;
        ev_lock = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (dem_s_q) begin
                    state_d = ST_PURGE;
                end
            end
            ST_PURGE: begin
                if (!dem_s_q) begin
                    state_d = ST_IDLE;
                end else if (purge_done) begin
                    state_d = ST_IGNITE;
                end
            end
            ST_IGNITE: begin
                if (ign_done && !flame_s_q) begin
                    state_d = ST_LOCK;
                    ev_lock = 1'b1;
                end else if (ign_done) begin
                    state_d = stab_zero ? ST_RUN : ST_STAB;
                end
            end
            ST_STAB, ST_RUN: begin
                if (!flame_s_q) begin
                    ev_flame = 1'b1;
                    ev_lock = !run_recycle;
                    state_d = run_recycle ? ST_PURGE : ST_LOCK;
                end else if (stack_trip) begin
                    ev_stack = 1'b1;
                    ev_lock = !stack_recycle;
                    state_d = stack_recycle ? ST_HOLD : ST_LOCK;
                end else if (!dem_s_q) begin
                    state_d = ST_IDLE;
                end else if (state_q == ST_STAB && (stab_done || stab_zero)) begin
                    state_d = ST_RUN;
                end
            end
            ST_HOLD: begin
                if (dly_done || stack_dly_q == 16'h0000) begin
                    state_d = dem_s_q ? ST_PURGE : ST_IDLE;
                end
            end
            ST_LOCK: begin
                if (!dem_s_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // State, its second timer and the registered drive outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            seq_sec_q <= 16'h0000;
            ign_q <= 1'b0;
            valve_q <= 1'b0;
            fan_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                seq_sec_q <= 16'h0000;
            end else if (sec_tick) begin
                seq_sec_q <= seq_nx;
            end
            ign_q <= state_d == ST_IGNITE;
            valve_q <= state_d == ST_IGNITE || state_d == ST_STAB || state_d == ST_RUN;
            fan_q <= state_d != ST_IDLE && state_d != ST_LOCK && state_d != ST_HOLD;
            lock_q <= state_d == ST_LOCK;
        end
    end

    // Slow start is active only below its setpoint.
    wire slow_active = slow_en && (outlet_temp < slow_sp_q);
    wire [8:0] ceil_sum = {1'b0, ceil_q} + {1'b0, ramp_q};
    wire [7:0] ceil_nx = (ceil_sum > {1'b0, RATE_MAX}) ? RATE_MAX : ceil_sum[7:0];

    // Stepped limiting in bands below the stack setpoint.
    wire [17:0] st_1 = {2'b00, stack_temp} + {2'b00, band_q};
    wire [17:0] st_2 = st_1 + {2'b00, band_q};
    wire [17:0] st_3 = st_2 + {2'b00, band_q};
    wire [17:0] sp_w = {2'b00, stack_sp_q};
    wire [7:0] stack_cap = !stack_en ? RATE_MAX : (st_1 >= sp_w) ? STEP_CAP3 :
        (st_2 >= sp_w) ? STEP_CAP2 : (st_3 >= sp_w) ? STEP_CAP1 : RATE_MAX;

    // Run rate: request clamped, then slow start and stack caps.
    wire [7:0] req_c = (rate_req > RATE_MAX) ? RATE_MAX : rate_req;
    wire [7:0] req_s = (slow_active && req_c > ceil_q) ? ceil_q : req_c;
    wire [7:0] req_l = (req_s > stack_cap) ? stack_cap : req_s;
    // The rate follows the next state, so it changes on the same edge as the drive outputs.
    always_comb begin
        case (state_d)
            ST_PURGE: rate_d = PREPURGE_RATE;
            ST_IGNITE: rate_d = lightoff_q;
            ST_STAB: rate_d = lightoff_q;
            ST_RUN: rate_d = req_l;
            default: rate_d = 8'h00;
        endcase
    end

    // Rate and the slow start ceiling, which grows by the ramp each minute.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q <= 8'h00;
            ceil_q <= 8'h00;
        end else begin
            rate_q <= rate_d;
            if (!slow_active) begin
                ceil_q <= rate_q;
            end else if (min_tick) begin
                ceil_q <= ceil_nx;
            end
        end
    end

    // System pump: manual on, or demand with overrun in auto.
    wire ovr_end = sec_tick && (ovr_sec_q + 16'h0001 >= overrun_q);
    wire pump_auto = dem_s_q || (ovr_run_q && overrun_q != 16'h0000);
    wire pump_d = pump_manual || pump_auto;
    wire routed = pump_q && (pump_sel != 2'b00);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_run_q <= 1'b0;
            ovr_sec_q <= 16'h0000;
            pump_q <= 1'b0;
            routed_prev_q <= 1'b0;
        end else begin
            if (dem_s_q) begin
                ovr_run_q <= 1'b1;
                ovr_sec_q <= 16'h0000;
            end else if (ovr_run_q && ovr_end) begin
                ovr_run_q <= 1'b0;
            end else if (ovr_run_q && sec_tick) begin
                ovr_sec_q <= ovr_sec_q + 16'h0001;
            end
            pump_q <= pump_d;
            routed_prev_q <= routed;
        end
    end

    // Route the pump function to one output or to none.
    genvar gi;
    generate
        for (gi = 0; gi < PUMP_OUTS; gi++) begin : g_pump
            assign pump_out[gi] = pump_q && (pump_sel == 2'(gi + 1));
        end
    endgenerate
    wire pump_rise = routed && !routed_prev_q;

    // Outlet temperature shown in the selected units.
    wire [15:0] f_off = (outlet_temp > F_OFFSET) ? outlet_temp - F_OFFSET : 16'h0000;
    wire [27:0] c_prod = f_off * C_SCALE;
    wire [15:0] temp_disp = celsius ? c_prod[C_SHIFT+15:C_SHIFT] : outlet_temp;

    // APB decode; registers answer at the access cycle without wait states.
    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite && !pslverr;
    wire h_ctrl = paddr == OFS_CTRL;
    wire h_lo = paddr == OFS_LIGHTOFF;
    wire h_stab = paddr == OFS_STAB;
    wire h_ramp = paddr == OFS_RAMP;
    wire h_ssp = paddr == OFS_SLOW_SP;
    wire h_ksp = paddr == OFS_STACK_SP;
    wire h_kdl = paddr == OFS_STACK_DLY;
    wire h_band = paddr == OFS_STACK_BAND;
    wire h_ovr = paddr == OFS_OVERRUN;
    wire h_pwm = paddr == OFS_PWM_DIV;
    wire h_cyc = paddr == OFS_CYCLES;
    wire h_sts = paddr == OFS_STATUS;
    wire h_ists = paddr == OFS_IRQ_STS;
    wire h_imsk = paddr == OFS_IRQ_MASK;
    wire h_tmp = paddr == OFS_TEMP_DISP;
    wire hit = h_ctrl | h_lo | h_stab | h_ramp | h_ssp | h_ksp | h_kdl | h_band | h_ovr
        | h_pwm | h_cyc | h_sts | h_ists | h_imsk | h_tmp;
    wire [31:0] status_w = {16'h0000, rate_q, 1'b0, state_q, pump_q, lock_q, flame_s_q, dem_s_q};
    wire [31:0] rd_mux = h_ctrl ? {22'h0, ctrl_q} : h_lo ? {24'h0, lightoff_q} :
        h_stab ? {16'h0, stab_q} : h_ramp ? {24'h0, ramp_q} : h_ssp ? {16'h0, slow_sp_q} :
        h_ksp ? {16'h0, stack_sp_q} : h_kdl ? {16'h0, stack_dly_q} :
        h_band ? {16'h0, band_q} : h_ovr ? {16'h0, overrun_q} :
        h_pwm ? {16'h0, pwm_div_q} : h_cyc ? cycles_q : h_sts ? status_w :
        h_ists ? {28'h0, irq_sts_q} : h_imsk ? {28'h0, irq_mask_q} :
        h_tmp ? {16'h0, temp_disp} : 32'h0000_0000;

    // Configuration registers written in the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            lightoff_q <= LIGHTOFF_RST;
            stab_q <= 16'h0000;
            ramp_q <= 8'h00;
            slow_sp_q <= 16'h0000;
            stack_sp_q <= 16'hffff;
            stack_dly_q <= 16'h0000;
            band_q <= 16'h0000;
            overrun_q <= 16'h0000;
            pwm_div_q <= PWM_DIV_RST;
            irq_mask_q <= '0;
            prdata_q <= 32'h0000_0000;
        end else begin
            if (wr && h_ctrl) ctrl_q <= pwdata[CTRL_W-1:0];
            if (wr && h_lo) lightoff_q <= pwdata[7:0];
            if (wr && h_stab) stab_q <= pwdata[15:0];
            if (wr && h_ramp) ramp_q <= pwdata[7:0];
            if (wr && h_ssp) slow_sp_q <= pwdata[15:0];
            if (wr && h_ksp) stack_sp_q <= pwdata[15:0];
            if (wr && h_kdl) stack_dly_q <= pwdata[15:0];
            if (wr && h_band) band_q <= pwdata[15:0];
            if (wr && h_ovr) overrun_q <= pwdata[15:0];
            if (wr && h_pwm) pwm_div_q <= pwdata[15:0];
            if (wr && h_imsk) irq_mask_q <= pwdata[IRQ_W-1:0];
            if (setup) prdata_q <= rd_mux;
        end
    end

    // Cycle counter and sticky interrupt bits; a new event beats a clear.
    assign irq_ev = {pump_rise, ev_lock, ev_stack, ev_flame};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycles_q <= 32'h0000_0000;
            irq_sts_q <= '0;
        end else begin
            if (wr && h_cyc) begin
                cycles_q <= pwdata;
            end else if (pump_rise) begin
                cycles_q <= cycles_q + 32'h0000_0001;
            end
            irq_sts_q <= (irq_sts_q & ~((wr && h_ists) ? pwdata[IRQ_W-1:0] : '0)) | irq_ev;
        end
    end

    // Fan drive modulator.
    blps_pwm u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .div(pwm_div_q),
        .duty(rate_q),
        .pwm_out(fan_pwm)
    );

    // Output assignments.
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign fan_on = fan_q;
    assign igniter_on = ign_q;
    assign valve_on = valve_q;
    assign lockout = lock_q;
    assign mod_rate = rate_q;
    assign units_celsius = celsius;
    assign irq = |(irq_sts_q & irq_mask_q);

endmodule

/* blps_chk_sva.sv */
// Concurrent checks on the ports of the burner, limit and pump sequencer.
// Assumes one pclk domain with presetn as its asynchronous reset.
module blps_chk
    import blps_pkg::*;
#(
    parameter int TICKS_PER_SEC_P = 100,
    parameter int PUMP_OUTS = 3
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bus and pins watched.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pslverr,
    input wire logic flame_in,
    input wire logic demand_in,
    input wire logic fan_on,
    input wire logic igniter_on,
    input wire logic valve_on,
    input wire logic [7:0] mod_rate,
    input wire logic [PUMP_OUTS-1:0] pump_out,
    input wire logic units_celsius
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A completed write strobe, used to excuse changes caused by software.
    wire wr_done = psel && penable && pwrite;

    AST_PURGE_RATE: assert property (fan_on && !valve_on |-> mod_rate == PREPURGE_RATE)
        else $error("purge rate wrong");
    AST_LIGHT_VIA_IGN: assert property ($rose(valve_on) |-> igniter_on)
        else $error("valve opened outside ignition");
    AST_FLAME_RECYCLE: assert property (
        valve_on && !igniter_on && demand_in && $fell(flame_in) |-> ##[1:5] !valve_on)
        else $error("flame loss did not stop firing");
    AST_IDLE_ZERO: assert property (!fan_on |-> mod_rate == 8'h00)
        else $error("rate nonzero while not firing");
    AST_RATE_MAX: assert property (mod_rate <= RATE_MAX)
        else $error("rate above maximum");
    AST_PUMP_ONE: assert property ($onehot0(pump_out))
        else $error("pump function on two outputs");
    AST_UNITS_WRITE: assert property (
        $changed(units_celsius) |-> $past(wr_done) && $past(paddr) == OFS_CTRL)
        else $error("units changed without a write");
    AST_PUMP_OFF: assert property (
        $fell(|pump_out) && !$past(wr_done) |-> $past(!demand_in, 2))
        else $error("pump stopped while demand present");
    AST_SLVERR: assert property (psel && penable && paddr > OFS_TEMP_DISP |-> pslverr)
        else $error("unmapped access not flagged");
endmodule

bind blps_top blps_chk #(.TICKS_PER_SEC_P(TICKS_PER_SEC_P), .PUMP_OUTS(PUMP_OUTS)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pslverr(pslverr), .flame_in(flame_in), .demand_in(demand_in),
    .fan_on(fan_on), .igniter_on(igniter_on), .valve_on(valve_on), .mod_rate(mod_rate),
    .pump_out(pump_out), .units_celsius(units_celsius));

/* blps_plant.sv */
// Flame model of the burner: flame follows the gas valve after a short delay.
// Assumes the bench raises kill to simulate a flame failure.
module blps_plant (
    // Clock.
    input wire logic pclk,
    // Burner side.
    input wire logic valve_on,
    input wire logic kill,
    output logic flame_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] dly_q = 3'h0;

    // Flame takes three cycles to prove, and drops as soon as it is killed.
    always @(posedge pclk) begin
        dly_q <= {dly_q[1:0], valve_on && !kill};
    end
    assign flame_in = dly_q[2] && !kill;
endmodule

/* test_burner_limit_pump_sequencer.sv */
// Self-checking bench of the sequencer over APB with a flame model.
// Assumes a one-second tick of 100 pclk cycles so sequences stay short.
module test_burner_limit_pump_sequencer
    import blps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, flame_in, demand_in = 1'b0, kill = 1'b0;
    logic [15:0] outlet_temp = 16'h0050, stack_temp = 16'h0064;
    logic [7:0] rate_req = 8'h3c, mod_rate;
    logic fan_on, fan_pwm, igniter_on, valve_on, lockout, units_celsius, irq;
    logic [2:0] pump_out;
    int num_errors = 0, checked = 0;
    time t0;

    always #4 pclk = ~pclk;

    blps_top #(.TICKS_PER_SEC_P(100), .PUMP_OUTS(3)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .flame_in(flame_in),
        .demand_in(demand_in), .outlet_temp(outlet_temp), .stack_temp(stack_temp),
        .rate_req(rate_req), .fan_on(fan_on), .fan_pwm(fan_pwm), .igniter_on(igniter_on),
        .valve_on(valve_on), .lockout(lockout), .mod_rate(mod_rate), .pump_out(pump_out),
        .units_celsius(units_celsius), .irq(irq));
    blps_plant plant (.pclk(pclk), .valve_on(valve_on), .kill(kill), .flame_in(flame_in));

    // One APB transfer; read data and error are taken at the edge where pready is high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Compare and count; a mismatch is printed at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Poll the state field of the status register under a bounded count.
    task automatic wstate(input blps_state_t st);
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[6:4] !== st && n < 2000);
        chk(rd[6:4], st);
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Cuts a hang short; the tests need about 13000 cycles.
    initial begin
        #(8 * 60000);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(OFS_CTRL, 32'h101);
        rdchk(OFS_STACK_SP, 32'hffff);
        rdchk(OFS_LIGHTOFF, 32'h19);
        apb(1'b0, 12'hffc, 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        apb(1'b1, OFS_STAB, 32'h2);
        apb(1'b1, OFS_OVERRUN, 32'h2);
        apb(1'b1, OFS_CYCLES, 32'h100);
        demand_in <= 1'b1;
        wstate(ST_STAB);
        chk(mod_rate, 8'h19);
        wstate(ST_RUN);
        chk(mod_rate, 8'h3c);
        chk(pump_out, 3'b001);
        rdchk(OFS_CYCLES, 32'h101);
        // Fan drive period is 100 clocks per divider step.
        apb(1'b1, OFS_PWM_DIV, 32'h1);
        repeat (2) @(posedge fan_pwm);
        t0 = $time;
        @(posedge fan_pwm);
        chk(32'(($time - t0) / 8), 32'd100);
        // Slow start holds the rate and lets it climb by the ramp each minute.
        apb(1'b1, OFS_RAMP, 32'ha);
        apb(1'b1, OFS_SLOW_SP, 32'hc8);
        apb(1'b1, OFS_CTRL, 32'h103);
        rate_req <= 8'h64;
        repeat (10) @(posedge pclk);
        chk(mod_rate, 8'h3c);
        repeat (6050) @(posedge pclk);
        chk(mod_rate == 8'h46 || mod_rate == 8'h50, 1'b1);
        outlet_temp <= 16'h00d2;
        repeat (10) @(posedge pclk);
        chk(mod_rate, 8'h64);
        // Stepped limit near the stack setpoint, then trip with recycle and delay.
        apb(1'b1, OFS_CTRL, 32'h10d);
        apb(1'b1, OFS_STACK_SP, 32'hc8);
        apb(1'b1, OFS_STACK_BAND, 32'ha);
        apb(1'b1, OFS_STACK_DLY, 32'h2);
        stack_temp <= 16'h00c3;
        repeat (10) @(posedge pclk);
        chk(mod_rate, 8'h19);
        stack_temp <= 16'h00d2;
        wstate(ST_HOLD);
        chk({valve_on, irq}, 2'b01);
        stack_temp <= 16'h0064;
        apb(1'b1, OFS_IRQ_STS, 32'hf);
        chk(irq, 1'b0);
        apb(1'b1, OFS_STAB, 32'h0);
        wstate(ST_PURGE);
        wstate(ST_RUN);
        chk(mod_rate, 8'h64);
        // Flame loss in run recycles; the masked event leaves irq low.
        kill <= 1'b1;
        wstate(ST_PURGE);
        kill <= 1'b0;
        chk(irq, 1'b0);
        rdchk(OFS_IRQ_STS, 32'h1);
        // With the stack limit disabled an overheated stack does nothing.
        apb(1'b1, OFS_CTRL, 32'h109);
        stack_temp <= 16'h00d2;
        wstate(ST_RUN);
        repeat (20) @(posedge pclk);
        wstate(ST_RUN);
        chk(mod_rate, 8'h64);
        // Pump overrun, manual run, routing and temperature units.
        demand_in <= 1'b0;
        wstate(ST_IDLE);
        chk(pump_out, 3'b001);
        repeat (250) @(posedge pclk);
        chk(pump_out, 3'b000);
        apb(1'b1, OFS_CTRL, 32'h110);
        repeat (300) @(posedge pclk);
        chk(pump_out, 3'b001);
        rdchk(OFS_CYCLES, 32'h102);
        outlet_temp <= 16'h00d4;
        apb(1'b1, OFS_CTRL, 32'h330);
        chk({units_celsius, pump_out}, 4'b1100);
        rdchk(OFS_TEMP_DISP, 32'h64);
        apb(1'b1, OFS_CTRL, 32'h000);
        chk({units_celsius, pump_out}, 4'b0000);
        rdchk(OFS_TEMP_DISP, 32'hd4);
        // Without a proven flame the ignition ends in lockout.
        kill <= 1'b1;
        demand_in <= 1'b1;
        wstate(ST_IGNITE);
        chk({igniter_on, valve_on, fan_on, lockout}, 4'b1110);
        wstate(ST_LOCK);
        chk({igniter_on, valve_on, fan_on, lockout}, 4'b0001);
        rdchk(OFS_IRQ_STS, 32'hd);
        report_and_stop();
    end
endmodule
